// File: core/rfsd_pkg.sv
/*
  constants, types and register map of the receive frame slave dma block.
  assumes a 100 MHz core clock and a word-addressed avalon-mm register bus.
*/
`default_nettype none
package rfsd_pkg;
  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [10:0] IX_SOF    = 11'h026;
  localparam logic [10:0] IX_FCNT   = 11'h028;
  localparam logic [10:0] IX_BCNT   = 11'h02A;
  localparam logic [10:0] IX_CHAN   = 11'h374;
  localparam logic [10:0] IX_RXST   = 11'h400;
  localparam logic [10:0] IX_RXLEN  = 11'h402;
  localparam logic [10:0] IX_RECEIVE_CONFIG_REGISTER  = 11'h102;
  localparam logic [10:0] IX_RXEV   = 11'h104;
  localparam logic [10:0] IX_BUFFER_IRQ_CONFIG = 11'h10A;
  localparam logic [10:0] IX_BUFEV  = 11'h10C;
  localparam logic [10:0] IX_BUS_CONTROL_REGISTER = 11'h116;
  localparam logic [10:0] IX_MISS   = 11'h130;
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_BATCH = 7;
  localparam int B_EXCL  = 9;
  localparam int B_AUTO  = 10;
  localparam int B_RRST  = 6;
  localparam int B_BURST = 11;
  localparam int B_RSIZE = 13;
  localparam int B_IRQEN = 7;
  localparam int B_MOVED = 7;
  localparam int B_MISS  = 6;
  // ****************************************
  // reset values and ring masks
  // ****************************************
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [1:0]  CHAN_RST = 2'h0;
  localparam logic [15:0] MASK_16K = 16'h3FFF;
  localparam logic [15:0] MASK_64K = 16'hFFFF;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS       = 10;
  localparam int BURST_ON_NS  = 28000;
  localparam int BURST_OFF_NS = 1300;
  localparam logic [11:0] ON_CYC  = 12'(BURST_ON_NS / CLK_NS);
  localparam logic [11:0] OFF_CYC = 12'((BURST_OFF_NS + CLK_NS - 1) / CLK_NS);
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] len;
  } rfsd_hdr_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_XFER = 3'h2,
    S_DONE = 3'h4
  } rfsd_state_t;
endpackage
`default_nettype wire

// File: core/rfsd_top.sv
/*
  receive frame slave dma: moves accepted frames from on-chip ram to a
  host ring over a request/acknowledge pin pair, with avalon-mm registers.
  assumes the on-chip ram side presents a whole accepted frame with its
  header and a first-word-fall-through data word, advanced by a pop.
*/
// Operation
// - exclusive dma bit sends every received frame through dma
// - exclusive bit wins over auto-switch enable
// - channel 0..2 selects one of three request/ack pin pairs
// - ring is 16 kbytes with size bit clear, 64 kbytes set
// - size bit only shapes offsets; base address never stored
// - request rises only after a frame is fully accepted on chip
// - status word, then length word, then frame data
// - pacing bit clear keeps request high until the last word
// - pacing bit set: about 28 us request, 1.3 us gap
// - request drops before last word; one more cycle accepted
// - completion updates offset, counts, flag and frees on-chip space
// - completion raises interrupt when enabled
// - frame count 12 bits and byte count, both since last read
// - frames lost for space bump missed counter in any mode
// - receive event reads zero while in dma mode
// - committed host space is never overwritten
// - second count read, implied skip or ring reset frees space
// - frames written as words, each starting 32-bit aligned
// - moved flag follows nonzero frame count; event read keeps it
// - batching mode sets flag at batch end, clears at zero count
// - start offset holds 16-bit offset of latest frame
`timescale 1ns/1ns
`default_nettype none
module rfsd_top #(
  parameter int CHANNELS = 3
) (
  input  wire logic               CORE_CLK_IN,
  input  wire logic               SRST_IN,
  input  wire logic [10:0]        AVS_ADDRESS_IN,
  input  wire logic               AVS_READ_IN,
  input  wire logic               AVS_WRITE_IN,
  input  wire logic [31:0]        AVS_WRITEDATA_IN,
  input  wire logic [3:0]         AVS_BYTEENABLE_IN,
  output logic      [31:0]        AVS_READDATA_OUT,
  output logic                    AVS_WAITREQUEST_OUT,
  input  wire logic               FRAME_READY_IN,
  input  wire rfsd_pkg::rfsd_hdr_t FRAME_HDR_IN,
  input  wire logic [15:0]        FRAME_DATA_IN,
  output logic                    FRAME_POP_OUT,
  output logic                    FRAME_FREE_OUT,
  input  wire logic               AUTO_NEED_IN,
  input  wire logic               BATCH_END_IN,
  input  wire logic               MISS_IN,
  input  wire logic [15:0]        RX_EVENT_IN,
  output logic      [2:0]         DMA_REQ_OUT,
  input  wire logic [2:0]         DMA_ACK_N_IN,
  output logic      [15:0]        DMA_DATA_OUT,
  output logic                    IRQ_OUT
);
  import rfsd_pkg::*;

  if (CHANNELS != 3) begin : g_chk
    $error("three channels only");
  end

  // ****************************************
  // register bus: one wait cycle, effects at first edge
  // ****************************************
  logic        resp;
  logic [15:0] receive_config_register, buffer_irq_config, bus_control_register, sof, bcnt;
  logic [11:0] fcnt;
  logic [9:0]  miss;
  logic [1:0]  chan;
  logic        flag, newf, cvalid;
  logic [15:0] cstart, ustart, wroff, fstart;
  rfsd_hdr_t   hdr;
  rfsd_state_t state;
  logic [15:0] wcnt, total;
  logic [11:0] pc;
  logic        pace_on;
  logic [2:0]  ack_s1, ack_s2, ack_s3;

  wire bus_req = AVS_READ_IN | AVS_WRITE_IN;
  wire stb     = bus_req & ~resp;
  wire rd      = stb & AVS_READ_IN;
  wire wr      = stb & AVS_WRITE_IN;
  wire a_fcnt  = AVS_ADDRESS_IN == IX_FCNT;
  wire a_bcnt  = AVS_ADDRESS_IN == IX_BCNT;
  wire a_miss  = AVS_ADDRESS_IN == IX_MISS;
  wire a_bufev = AVS_ADDRESS_IN == IX_BUFEV;
  wire a_bus_control_register = AVS_ADDRESS_IN == IX_BUS_CONTROL_REGISTER;
  wire [15:0] wmask = {{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
  wire [15:0] wd    = AVS_WRITEDATA_IN[15:0];
  wire ring_rst = wr & a_bus_control_register & wmask[B_RRST] & wd[B_RRST];

  assign AVS_WAITREQUEST_OUT = stb;

  // ****************************************
  // mode decode
  // ****************************************
  // exclusive bit forces dma whatever the auto-switch side asks
  wire dma_on  = receive_config_register[B_EXCL] | (receive_config_register[B_AUTO] & AUTO_NEED_IN);
  wire batch   = receive_config_register[B_BATCH];
  // only the offset logic sees the ring size
  wire [15:0] mask = bus_control_register[B_RSIZE] ? MASK_64K : MASK_16K;
  wire chan_ok = chan != 2'h3;

  // ****************************************
  // frame geometry
  // ****************************************
  // header plus data rounded up to a double word
  wire [16:0] tb_in   = (17'(FRAME_HDR_IN.len) + 17'h00007) & 17'h1FFFC;
  wire [16:0] tb_cur  = (17'(hdr.len) + 17'h00007) & 17'h1FFFC;
  wire [15:0] dwords  = 16'((17'(hdr.len) + 17'h00001) >> 1);
  wire [15:0] left    = total - wcnt;
  wire [15:0] free_sp = (cstart - wroff) & mask;
  // committed space must not be entered by the next frame
  wire fits    = ~cvalid | (tb_in <= 17'(free_sp));
  wire go      = (state == S_IDLE) & dma_on & FRAME_READY_IN & fits;

  // ****************************************
  // ack synchroniser and transfer edge
  // ****************************************
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      ack_s1 <= 3'h7;
      ack_s2 <= 3'h7;
      ack_s3 <= 3'h7;
    end else begin
      ack_s1 <= DMA_ACK_N_IN;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end
  // a word is taken when the host releases its ack
  wire word_done = (state == S_XFER) & chan_ok & ~ack_s3[chan] & ack_s2[chan];
  wire in_data   = (wcnt >= 16'h0002) & ((wcnt - 16'h0002) < dwords);
  assign FRAME_POP_OUT  = word_done & in_data;
  assign FRAME_FREE_OUT = state == S_DONE;

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      state  <= S_IDLE;
      wcnt   <= 16'h0000;
      total  <= 16'h0000;
      hdr    <= '0;
      fstart <= 16'h0000;
    end else begin
      unique case (state)
        S_IDLE: if (go) begin
          state  <= S_XFER;
          hdr    <= FRAME_HDR_IN;
          total  <= 16'(tb_in >> 1);
          wcnt   <= 16'h0000;
          fstart <= wroff;
        end
        S_XFER: if (word_done) begin
          wcnt <= wcnt + 16'h0001;
          // the extra cycle after the request fell ends the frame
          if (left == 16'h0001) state <= S_DONE;
        end
        S_DONE: state <= S_IDLE;
      endcase
    end
  end

  // status, length, data, then zero fill to alignment
  wire [15:0] next_dout = (wcnt == 16'h0000) ? hdr.status :
                          (wcnt == 16'h0001) ? hdr.len :
                          in_data ? FRAME_DATA_IN : 16'h0000;
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) DMA_DATA_OUT <= 16'h0000;
    else DMA_DATA_OUT <= next_dout;
  end

  // ****************************************
  // burst pacing
  // ****************************************
  // gap lets other bus users in; counts only while moving a frame
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN || state != S_XFER || !bus_control_register[B_BURST]) begin
      pc      <= 12'h000;
      pace_on <= 1'b1;
    end else if (pace_on && pc == ON_CYC - 12'h001) begin
      pc      <= 12'h000;
      pace_on <= 1'b0;
    end else if (!pace_on && pc == OFF_CYC - 12'h001) begin
      pc      <= 12'h000;
      pace_on <= 1'b1;
    end else begin
      pc <= pc + 12'h001;
    end
  end

  // request held until one word is left on chosen pair
  // two words left bridges a gap: the host picks its next cycle before the
  // word in flight is counted, so a gap there would strand the last word
  wire req_on = (state == S_XFER) & (left > 16'h0001) & chan_ok &
                (pace_on | (left == 16'h0002));
  assign DMA_REQ_OUT = req_on ? 3'(3'h1 << chan) : 3'h0;

  // ****************************************
  // counters and flag
  // ****************************************
  wire done = state == S_DONE;
  // a completion in the read cycle survives the clear
  wire [11:0] next_fcnt = (rd & a_fcnt) ? 12'(done) : fcnt + 12'(done);
  wire [15:0] next_bcnt = (rd & a_bcnt) ? (done ? hdr.len : 16'h0000)
                                        : bcnt + (done ? hdr.len : 16'h0000);
  wire [9:0]  next_miss = (rd & a_miss) ? 10'(MISS_IN) : miss + 10'(MISS_IN);
  // batching sets only at batch end; both modes clear at zero
  wire next_flag = (next_fcnt == 12'h000) ? 1'b0 :
                   batch ? (flag | BATCH_END_IN) : 1'b1;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      fcnt <= 12'h000;
      bcnt <= 16'h0000;
      miss <= 10'h000;
      flag <= 1'b0;
      sof  <= 16'h0000;
    end else begin
      fcnt <= next_fcnt;
      bcnt <= next_bcnt;
      miss <= next_miss;
      flag <= next_flag;
      if (done) sof <= fstart;
    end
  end
  assign IRQ_OUT = flag & buffer_irq_config[B_IRQEN];

  // ****************************************
  // ring offsets and commitment
  // ****************************************
  wire skip = rd & a_bufev & flag & newf;
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN || ring_rst) begin
      wroff  <= 16'h0000;
      ustart <= 16'h0000;
      cstart <= 16'h0000;
      cvalid <= 1'b0;
      newf   <= 1'b0;
    end else begin
      if (done) wroff <= 16'(fstart + tb_cur[15:0]) & mask;
      if (rd & a_fcnt) begin
        // a read releases the old commit and commits what it reports
        cvalid <= fcnt != 12'h000;
        cstart <= ustart;
        ustart <= wroff;
        newf   <= done;
      end else begin
        if (skip) cvalid <= 1'b0;
        if (done) newf <= 1'b1;
      end
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      resp   <= 1'b0;
      receive_config_register  <= CFG_RST;
      buffer_irq_config <= CFG_RST;
      bus_control_register <= CFG_RST;
      chan   <= CHAN_RST;
    end else begin
      resp <= stb;
      if (wr && AVS_ADDRESS_IN == IX_RECEIVE_CONFIG_REGISTER) receive_config_register <= (receive_config_register & ~wmask) | (wd & wmask);
      if (wr && AVS_ADDRESS_IN == IX_BUFFER_IRQ_CONFIG) buffer_irq_config <= (buffer_irq_config & ~wmask) | (wd & wmask);
      // ring reset bit is a command and never stays set
      if (wr && a_bus_control_register) bus_control_register <= ((bus_control_register & ~wmask) | (wd & wmask)) & ~16'h0040;
      if (wr && AVS_ADDRESS_IN == IX_CHAN && AVS_BYTEENABLE_IN[0]) chan <= wd[1:0];
    end
  end

  logic [15:0] rmux;
  always_comb begin
    unique case (AVS_ADDRESS_IN)
      IX_SOF:    rmux = sof;
      IX_FCNT:   rmux = {4'h0, fcnt};
      IX_BCNT:   rmux = bcnt;
      IX_CHAN:   rmux = {14'h0000, chan};
      IX_RXST:   rmux = hdr.status;
      IX_RXLEN:  rmux = hdr.len;
      IX_RECEIVE_CONFIG_REGISTER:  rmux = receive_config_register;
      IX_RXEV:   rmux = dma_on ? 16'h0000 : RX_EVENT_IN;
      IX_BUFFER_IRQ_CONFIG: rmux = buffer_irq_config;
      IX_BUFEV:  rmux = {8'h00, flag, 7'h00};
      IX_BUS_CONTROL_REGISTER: rmux = bus_control_register;
      IX_MISS:   rmux = {miss, 6'h00};
      default:   rmux = 16'h0000;
    endcase
  end
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) AVS_READDATA_OUT <= 32'h0000_0000;
    else if (rd) AVS_READDATA_OUT <= {16'h0000, rmux};
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);

  req_after_frame_a: assert property (
    $rose(state == S_XFER) |-> $past(FRAME_READY_IN) && $past(dma_on))
    else $error("transfer began without an accepted frame");
  one_pair_a: assert property (
    DMA_REQ_OUT != 3'h0 |-> DMA_REQ_OUT == 3'(3'h1 << chan) && chan_ok)
    else $error("request on wrong pair");
  steady_req_a: assert property (
    state == S_XFER && !bus_control_register[B_BURST] && chan_ok && left > 16'h0001
    |-> DMA_REQ_OUT != 3'h0)
    else $error("request gap with pacing off");
  burst_len_a: assert property (
    $fell(pace_on) |-> $past(pc) == ON_CYC - 12'h001 ##1 !pace_on[*8])
    else $error("burst window length wrong");
  last_word_a: assert property (
    state == S_XFER && left == 16'h0001 |-> DMA_REQ_OUT == 3'h0)
    else $error("request held on last word");
  status_first_a: assert property (
    state == S_XFER && wcnt == 16'h0000 && !word_done |=> DMA_DATA_OUT == hdr.status)
    else $error("status word not first");
  count_up_a: assert property (
    done && !(rd && a_fcnt) |=> fcnt == $past(fcnt) + 12'h001 && sof == $past(fstart))
    else $error("completion not counted");
  event_zero_a: assert property (
    rd && AVS_ADDRESS_IN == IX_RXEV && dma_on |=> AVS_READDATA_OUT == 32'h0000_0000)
    else $error("event register not zero in dma mode");
  flag_count_a: assert property (
    !batch && !$past(batch) |-> flag == (fcnt != 12'h000))
    else $error("moved flag disagrees with count");
  // checked on the latched header and start, one edge after the frame began
  commit_guard_a: assert property (
    $rose(state == S_XFER) && $past(cvalid) && !$past(rd && a_fcnt) && !$past(ring_rst)
    |-> 17'((cstart - fstart) & mask) >= tb_cur)
    else $error("frame would overwrite committed space");
  irq_gate_a: assert property (
    IRQ_OUT |-> flag && buffer_irq_config[B_IRQEN])
    else $error("interrupt without flag");
  ring_wrap_a: assert property (
    $past(done) && !$past(ring_rst) |-> (wroff & ~mask) == 16'h0000)
    else $error("offset outside ring");
  // batching keeps the flag from setting until a batch ends
  batch_flag_a: assert property (
    $past(batch) && !$past(flag) && !$past(BATCH_END_IN) |-> !flag)
    else $error("moved flag set outside batch end");
  // counters move with their event unless a clearing read shares the edge
  miss_count_a: assert property (
    MISS_IN && !(rd && a_miss) |=> miss == $past(miss) + 10'h001)
    else $error("missed frame not counted");
  byte_count_a: assert property (
    done && !(rd && a_bcnt) |=> bcnt == $past(bcnt) + $past(hdr.len))
    else $error("bytes of a moved frame not counted");
  ring_rewind_a: assert property (
    ring_rst |=> wroff == 16'h0000 && !cvalid)
    else $error("ring reset left offset or commit");
  frame_align_a: assert property (
    $rose(state == S_XFER) |-> fstart[1:0] == 2'h0)
    else $error("frame start not double-word aligned");

  frame_done_c: cover property (state == S_XFER ##[1:1000] state == S_DONE);
  burst_gap_c:  cover property ($fell(pace_on));
  skip_c:       cover property (skip && cvalid);
  wrap_c:       cover property (done && (17'(fstart) + tb_cur) > 17'(mask));
  batch_end_c:  cover property (batch && $rose(flag));
endmodule
`default_nettype wire

// File: testbench/rfsd_host_dma.sv
/*
  host system dma controller model for the receive frame slave dma bench.
  assumes the device changes request and data only at rising clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module rfsd_host_dma (
  input  wire logic        clk_in,
  input  wire logic [1:0]  chan_in,
  input  wire logic        slow_in,
  input  wire logic [2:0]  req_in,
  input  wire logic [15:0] data_in,
  output var  logic [2:0]  ack_n_out
);
  // ****************************************
  // transfer cycles
  // ****************************************
  logic [15:0] words[$];
  logic        more;
  int          hold;
  initial ack_n_out = 3'h7;
  always begin
    @(posedge clk_in);
    more = (chan_in != 2'h3) && req_in[chan_in];
    // request latched once per cycle, so one more cycle follows its fall
    while (more) begin
      hold = slow_in ? 7 : 3;
      ack_n_out <= ~(3'h1 << chan_in);
      repeat (hold) @(posedge clk_in);
      more = req_in[chan_in];
      words.push_back(data_in);
      ack_n_out <= 3'h7;
      repeat (hold) @(posedge clk_in);
    end
  end
endmodule
`default_nettype wire

// File: testbench/rfsd_top_test.sv
/*
  self-checking bench of the receive frame slave dma block.
  assumes the host dma model is compiled before this file.
*/
`timescale 1ns/1ns
`default_nettype none
module rfsd_top_test;
  import rfsd_pkg::*;
  // ****************************************
  // stimulus, frame source and model state
  // ****************************************
  logic        clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, miss = 1'b0;
  logic        slow = 1'b0, fr_rdy = 1'b0, prev = 1'b0, bend = 1'b0, pop, free, wreq, irq;
  logic [10:0] addr = 11'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [15:0] rx_ev = 16'h0, fr_st = 16'h0, fr_len = 16'h0, ddata, q;
  logic [15:0] fr_seed = 16'h0, fr_idx = 16'h0;
  logic [1:0]  chan = 2'h0;
  logic [2:0]  req, ack_n;
  logic [47:0] src_q[$], ex_q[$];
  rfsd_hdr_t   hdr;
  int          n_fail = 0, n_tests = 0, n_free = 0, n_push = 0, falls = 0, fb = 0;
  int          run = 0, run_max = 0, wr_off = 0, exp_fc = 0, exp_bc = 0, exp_sof = 0;
  int          seed_v;
  assign hdr = {fr_st, fr_len};
  always #5 clk = ~clk;
  rfsd_top rfsd_top_i (
    .CORE_CLK_IN(clk), .SRST_IN(srst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .FRAME_READY_IN(fr_rdy),
    .FRAME_HDR_IN(hdr), .FRAME_DATA_IN(fr_seed ^ (fr_idx * 16'h1357)), .FRAME_POP_OUT(pop),
    .FRAME_FREE_OUT(free), .AUTO_NEED_IN(1'b0), .BATCH_END_IN(bend), .MISS_IN(miss),
    .RX_EVENT_IN(rx_ev), .DMA_REQ_OUT(req), .DMA_ACK_N_IN(ack_n), .DMA_DATA_OUT(ddata),
    .IRQ_OUT(irq)
  );
  rfsd_host_dma rfsd_host_dma_i (.clk_in(clk), .chan_in(chan), .slow_in(slow), .req_in(req),
    .data_in(ddata), .ack_n_out(ack_n));
  // frames are offered only once whole, one after another
  always @(posedge clk) begin
    if (free) begin
      fr_rdy <= 1'b0;
      n_free <= n_free + 1;
    end else if (!fr_rdy && src_q.size() > 0) begin
      {fr_st, fr_len, fr_seed} <= src_q.pop_front();
      fr_idx <= 16'h0;
      fr_rdy <= 1'b1;
    end else if (pop) begin
      fr_idx <= fr_idx + 16'h1;
    end
  end
  always @(posedge clk) begin
    prev <= |req;
    if (prev && !(|req)) falls <= falls + 1;
    run <= (|req) ? run + 1 : 0;
    if (run > run_max) run_max <= run;
    if (!srst && (req & ~(3'h1 << chan)) !== 3'h0) begin
      n_fail++;
      $display("CHECK FAILED request pins expected channel %0d seen %b", chan, req);
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [10:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wd <= {16'h0, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 16'h0, 16'h1);
    q = rdata[15:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [10:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    chk(nm, e, q);
  endtask
  task automatic push(input int len);
    logic [47:0] f;
    f = {16'($urandom), 16'(len), 16'($urandom)};
    src_q.push_back(f);
    ex_q.push_back(f);
    n_push++;
  endtask
  task automatic drain(input int ef);
    int n, nw, len;
    logic [15:0] st, ln, sd, e, mk, w;
    n = 0;
    while (n_free < n_push && n < 60000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 60000) chk("drain finished", 16'h0, 16'h1);
    repeat (10) @(posedge clk);
    if (ef >= 0) chk("request falls", 16'(ef), 16'(falls - fb));
    while (ex_q.size() > 0) begin
      {st, ln, sd} = ex_q.pop_front();
      len = int'(ln);
      nw = ((len + 7) & ~3) / 2;
      exp_sof = wr_off;
      wr_off = (wr_off + 2 * nw) & int'(MASK_16K);
      exp_fc++;
      exp_bc += len;
      for (int i = 0; i < nw; i++) begin
        w = rfsd_host_dma_i.words.pop_front();
        e = (i == 0) ? st : (i == 1) ? ln : sd ^ 16'((i - 2) * 16'h1357);
        mk = (i > (len + 1) / 2 + 1) ? 16'h0 : (len % 2 == 1 && i == (len + 1) / 2 + 1) ?
             16'h00FF : 16'hFFFF;
        chk("dma word", e & mk, w & mk);
      end
    end
    chk("surplus words", 16'h0, 16'(rfsd_host_dma_i.words.size()));
    fb = falls;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    close_out;
  end
  initial begin
    seed_v = $urandom(32'h2D82);
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rx_ev <= 16'($urandom);
    push(5);
    bus(1'b0, IX_RXEV, 16'h0);
    chk("rx event", rx_ev, q);
    repeat (20) @(posedge clk);
    chk("request with dma off", 16'h0, {13'h0, req});
    bus(1'b1, IX_BUFFER_IRQ_CONFIG, 16'(1 << B_IRQEN));
    for (int c = 0; c < 3; c++) begin
      chan <= 2'(c);
      slow <= (c == 2);
      bus(1'b1, IX_CHAN, 16'(c));
      bus(1'b1, IX_RECEIVE_CONFIG_REGISTER, (c == 1) ? 16'(3 << B_EXCL) : 16'(1 << B_EXCL));
      push(1 + $urandom % 60);
      push(2 * c + 1);
      drain((c == 0) ? 3 : 2);
      rdc("rx event in dma", IX_RXEV, 16'h0);
      chk("irq", 16'h1, {15'h0, irq});
      repeat (2) begin
        bus(1'b0, IX_BUFEV, 16'h0);
        chk("moved flag", 16'(1 << B_MOVED), q & 16'(1 << B_MOVED));
      end
      rdc("start offset", IX_SOF, 16'(exp_sof));
      rdc("frame count", IX_FCNT, 16'(exp_fc));
      rdc("byte count", IX_BCNT, 16'(exp_bc));
      exp_fc = 0;
      exp_bc = 0;
      rdc("frame count again", IX_FCNT, 16'h0);
      repeat (3) @(posedge clk);
      chk("irq cleared", 16'h0, {15'h0, irq});
    end
    repeat (3) begin
      @(posedge clk);
      miss <= 1'b1;
      @(posedge clk);
      miss <= 1'b0;
    end
    rdc("missed", IX_MISS, 16'(3 << B_MISS));
    rdc("missed cleared", IX_MISS, 16'h0);
    // ring reset rewinds the write offset, so the next frame starts at zero
    bus(1'b1, IX_BUS_CONTROL_REGISTER, 16'(1 << B_RRST));
    wr_off = 0;
    chan <= 2'h0;
    slow <= 1'b0;
    bus(1'b1, IX_CHAN, 16'h0);
    bus(1'b1, IX_BUS_CONTROL_REGISTER, 16'(1 << B_BURST));
    run_max = 0;
    push(1400);
    seed_v = fb;
    drain(-1);
    rdc("offset after rewind", IX_SOF, 16'h0);
    chk("burst split", 16'h1, 16'(fb - seed_v > 1));
    chk("burst length", 16'h1, 16'(run_max <= int'(ON_CYC) + 2));
    // batching: a committed ring, a frame moved, flag waits for the batch end
    bus(1'b1, IX_RECEIVE_CONFIG_REGISTER, 16'((1 << B_EXCL) | (1 << B_BATCH)));
    rdc("count before commit", IX_FCNT, 16'(exp_fc));
    exp_fc = 0;
    push(9);
    drain(1);
    bus(1'b0, IX_BUFEV, 16'h0);
    chk("flag before batch end", 16'h0, q & 16'(1 << B_MOVED));
    @(posedge clk);
    bend <= 1'b1;
    @(posedge clk);
    bend <= 1'b0;
    bus(1'b0, IX_BUFEV, 16'h0);
    chk("flag at batch end", 16'(1 << B_MOVED), q & 16'(1 << B_MOVED));
    chk("batched irq", 16'h1, {15'h0, irq});
    rdc("batched count", IX_FCNT, 16'(exp_fc));
    close_out;
  end
endmodule
`default_nettype wire
